// *** power_bias_regs.svh ***
// Bit positions, codes and values of the power-down and bias control word.
// Assumes inclusion by the package and the design files; definitions only.
`ifndef POWER_BIAS_REGS_SVH
`define POWER_BIAS_REGS_SVH

// Serial word size and bit counter width
`define WORD_BITS          32
`define BITCNT_W           6
`define WORD_BITS_CNT      6'h20

// Address fields carried in every written word
`define REG_NUM_LSB        0
`define REG_NUM_MSB        2
`define REG_NUM_THIS       3'h4
`define CHIP_ADDR_LSB      3
`define CHIP_ADDR_MSB      4
`define CHIP_ADDR_VAL      2'h3

// Control fields
`define CAL_BIT            5
`define BIAS_SEL_BIT       6
`define XBIAS_LSB          7
`define XBIAS_MSB          8
`define XGAIN_LSB          9
`define XGAIN_MSB          11
`define RXBIAS_LSB         12
`define RXBIAS_MSB         16
`define TX_MOD_BIT         17
`define TX_ATT_BIT         18
`define TX_DRV_BIT         19
`define TX_OUT_BIT         20
`define TCONV_BIT          21
`define TSENS_BIT          22
`define OFFS_BIT           23
`define XAMP_BIT           24
`define LNA_BIT            25
`define VGA1_BIT           26
`define VGA2_BIT           27
`define VGA3_BIT           28
`define DEMOD_BIT          29
`define BB_BIT             30
`define RSV_BIT            31

// Power-on and recommended contents
`define POWER_ON_VALUE     32'h0060991C
`define SUGGESTED_VALUE    32'h0060751C

`endif

// *** power_bias_pkg.sv ***
// Types shared by the serial word receiver and the power and bias register.
// Assumes power_bias_regs.svh is on the include path.
`include "power_bias_regs.svh"

package power_bias_pkg;

  // Bias current flavour of the cross-polarization output amplifier
  typedef enum logic {
    constant_bias                 = 1'b0,
    temperature_proportional_bias = 1'b1
  } bias_type_t;

  // One complete serial word handed over by the receiver
  typedef struct packed {
    logic                    valid;
    logic [`WORD_BITS-1:0]   data;
  } ser_word_t;

  // Decoded controls driven to the analog blocks
  typedef struct packed {
    bias_type_t  crosspol_amp_bias_type_select;
    logic [1:0]  crosspol_amp_bias_code;
    logic [2:0]  crosspol_amp_gain_code;
    logic [4:0]  receive_gain_stage_bias_code;
    logic        tx_modulator_shutdown;
    logic        tx_attenuator_shutdown;
    logic        tx_driver_shutdown;
    logic        tx_output_stage_shutdown;
    logic        temp_converter_shutdown;
    logic        temp_sensor_shutdown;
    logic        rx_offset_loop_shutdown;
    logic        crosspol_amp_shutdown;
    logic        rx_input_amp_shutdown;
    logic        rx_gain_stage1_shutdown;
    logic        rx_gain_stage2_shutdown;
    logic        rx_gain_stage3_shutdown;
    logic        rx_demodulator_shutdown;
    logic        rx_baseband_shutdown;
  } pwr_bias_ctrl_t;

  // Calibration sequencer
  typedef enum logic [0:0] {
    CAL_IDLE,
    CAL_RUN
  } cal_state_t;

endpackage

// *** serial_word_receiver.sv ***
// Serial programming port: assembles one 32-bit word per latch pulse.
// Assumes the pins are asynchronous to clk and much slower than it.
`timescale 1ns/1ps
`default_nettype none
`include "power_bias_regs.svh"

module serial_word_receiver
  import power_bias_pkg::*;
(
  input  wire logic  clk,        // System clock
  input  wire logic  reset_n,    // Asynchronous reset, active low
  input  wire logic  ser_clk,    // Serial clock pin
  input  wire logic  ser_data,   // Serial data pin, bit 0 first
  input  wire logic  ser_latch,  // Latch enable pin, rising edge ends a word
  output ser_word_t  word        // Completed word with one-cycle valid
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0]            clk_sync_r;
  logic [2:0]            latch_sync_r;
  logic [1:0]            data_sync_r;
  logic [`WORD_BITS-1:0] shift_r;
  logic [`BITCNT_W-1:0]  count_r;
  ser_word_t             word_r;

  // Stage 0 feeds only stage 1; edges are taken from stages 1 and 2
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_sync_r   <= 3'h0;
      latch_sync_r <= 3'h0;
      data_sync_r  <= 2'h0;
    end else begin
      clk_sync_r   <= {clk_sync_r[1:0], ser_clk};
      latch_sync_r <= {latch_sync_r[1:0], ser_latch};
      data_sync_r  <= {data_sync_r[0], ser_data};
    end
  end

  wire logic sclk_rise  = clk_sync_r[1] & ~clk_sync_r[2];
  wire logic latch_rise = latch_sync_r[1] & ~latch_sync_r[2];
  wire logic full_word  = (count_r == `WORD_BITS_CNT);

  // ----------------------------------------------------------------
  // Shift register and handover
  // ----------------------------------------------------------------
  // A word of any other length than 32 bits is dropped whole
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= '0;
      count_r <= '0;
      word_r  <= '0;
    end else begin
      word_r.valid <= latch_rise & full_word;
      if (latch_rise) begin
        word_r.data <= shift_r;
        count_r     <= '0;
      end else if (sclk_rise && !latch_sync_r[1]) begin
        shift_r <= {data_sync_r[1], shift_r[`WORD_BITS-1:1]};
        if (count_r != {`BITCNT_W{1'b1}}) begin
          count_r <= count_r + 6'h01;
        end
      end
    end
  end

  assign word = word_r;

endmodule
`default_nettype wire

// *** power_bias_control_register.sv ***
// Power-down and bias control register with temperature converter calibration start.
// Assumes the serial pins and the calibration-done level are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "power_bias_regs.svh"

module power_bias_control_register
  import power_bias_pkg::*;
(
  input  wire logic        clk,             // System clock, 250 MHz
  input  wire logic        reset_n,         // Asynchronous reset, active low
  input  wire logic        ser_clk,         // Serial clock pin
  input  wire logic        ser_data,        // Serial data pin
  input  wire logic        ser_latch,       // Serial latch enable pin
  input  wire logic        temp_cal_done,   // Converter reports calibration finished
  output pwr_bias_ctrl_t   ctrl,            // Decoded bias and shutdown controls
  output logic [31:0]      reg_value,       // Current register contents
  output logic             write_accepted,  // One-cycle pulse per accepted word
  output logic             cal_start,       // One-cycle calibration start pulse
  output logic             cal_busy         // Calibration in progress
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True when a word carries this register's number and the chip address
  function automatic logic addr_match(input logic [`WORD_BITS-1:0] w);
    addr_match = (w[`REG_NUM_MSB:`REG_NUM_LSB] == `REG_NUM_THIS) &&
                 (w[`CHIP_ADDR_MSB:`CHIP_ADDR_LSB] == `CHIP_ADDR_VAL);
  endfunction

  // Calibration may only start while the converter is powered
  function automatic logic cal_request(input logic [`WORD_BITS-1:0] w);
    cal_request = w[`CAL_BIT] & ~w[`TCONV_BIT];
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ser_word_t             word;
  logic [`WORD_BITS-1:0] reg_r;
  logic [`WORD_BITS-1:0] reg_nxt;
  cal_state_t            cal_state_r;
  cal_state_t            cal_state_nxt;
  logic                  cal_start_r;
  logic                  accepted_r;
  logic [2:0]            done_sync_r;

  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  serial_word_receiver u_rx (
    .clk       (clk),
    .reset_n   (reset_n),
    .ser_clk   (ser_clk),
    .ser_data  (ser_data),
    .ser_latch (ser_latch),
    .word      (word)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic write_hit  = word.valid & addr_match(word.data);
  wire logic cal_req    = write_hit & cal_request(word.data);
  wire logic done_rise  = done_sync_r[1] & ~done_sync_r[2];
  wire logic conv_off   = write_hit & word.data[`TCONV_BIT];

  // Bit 31 is reserved and always stored as zero; bit 5 follows the sequencer
  wire logic cal_bit_nxt = (cal_state_nxt == CAL_RUN);

  always_comb begin
    reg_nxt = reg_r;
    if (write_hit) begin
      reg_nxt = word.data;
    end
    reg_nxt[`CAL_BIT] = cal_bit_nxt;
    reg_nxt[`RSV_BIT] = 1'b0;
  end

  // ----------------------------------------------------------------
  // Calibration sequencer
  // ----------------------------------------------------------------
  // Shutting the converter down mid-run abandons the calibration
  always_comb begin
    cal_state_nxt = cal_state_r;
    case (cal_state_r)
      CAL_IDLE: begin
        if (cal_req) begin
          cal_state_nxt = CAL_RUN;
        end
      end
      CAL_RUN: begin
        if (done_rise || conv_off) begin
          cal_state_nxt = CAL_IDLE;
        end
      end
      default: begin
        cal_state_nxt = CAL_IDLE;
      end
    endcase
  end

  wire logic start_nxt = (cal_state_r == CAL_IDLE) && (cal_state_nxt == CAL_RUN);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_sync_r <= 3'h0;
    end else begin
      done_sync_r <= {done_sync_r[1:0], temp_cal_done};
    end
  end

  // Power-on contents leave the temperature blocks shut down
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_r       <= `POWER_ON_VALUE;
      cal_state_r <= CAL_IDLE;
      cal_start_r <= 1'b0;
      accepted_r  <= 1'b0;
    end else begin
      reg_r       <= reg_nxt;
      cal_state_r <= cal_state_nxt;
      cal_start_r <= start_nxt;
      accepted_r  <= write_hit;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign ctrl.crosspol_amp_bias_type_select = bias_type_t'(reg_r[`BIAS_SEL_BIT]);
  assign ctrl.crosspol_amp_bias_code        = reg_r[`XBIAS_MSB:`XBIAS_LSB];
  assign ctrl.crosspol_amp_gain_code        = reg_r[`XGAIN_MSB:`XGAIN_LSB];
  assign ctrl.receive_gain_stage_bias_code  = reg_r[`RXBIAS_MSB:`RXBIAS_LSB];
  assign ctrl.tx_modulator_shutdown         = reg_r[`TX_MOD_BIT];
  assign ctrl.tx_attenuator_shutdown        = reg_r[`TX_ATT_BIT];
  assign ctrl.tx_driver_shutdown            = reg_r[`TX_DRV_BIT];
  assign ctrl.tx_output_stage_shutdown      = reg_r[`TX_OUT_BIT];
  assign ctrl.temp_converter_shutdown       = reg_r[`TCONV_BIT];
  assign ctrl.temp_sensor_shutdown          = reg_r[`TSENS_BIT];
  assign ctrl.rx_offset_loop_shutdown       = reg_r[`OFFS_BIT];
  assign ctrl.crosspol_amp_shutdown         = reg_r[`XAMP_BIT];
  assign ctrl.rx_input_amp_shutdown         = reg_r[`LNA_BIT];
  assign ctrl.rx_gain_stage1_shutdown       = reg_r[`VGA1_BIT];
  assign ctrl.rx_gain_stage2_shutdown       = reg_r[`VGA2_BIT];
  assign ctrl.rx_gain_stage3_shutdown       = reg_r[`VGA3_BIT];
  assign ctrl.rx_demodulator_shutdown       = reg_r[`DEMOD_BIT];
  assign ctrl.rx_baseband_shutdown          = reg_r[`BB_BIT];

  assign reg_value      = reg_r;
  assign write_accepted = accepted_r;
  assign cal_start      = cal_start_r;
  assign cal_busy       = (cal_state_r == CAL_RUN);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_cal_start;
    (cal_state_r == CAL_IDLE) && cal_req |=> cal_start && cal_busy ##1 !cal_start;
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("calibration did not start on request");

  property p_cal_refused;
    write_hit && word.data[`CAL_BIT] && word.data[`TCONV_BIT] && !cal_busy |=> !cal_start [*2];
  endproperty
  a_cal_refused: assert property (p_cal_refused)
    else $error("calibration started while converter shut down");

  property p_cal_end;
    cal_busy && done_rise |=> !cal_busy && !reg_value[`CAL_BIT];
  endproperty
  a_cal_end: assert property (p_cal_end)
    else $error("calibration did not end on done");

  property p_bias_fields;
    write_hit |=> ctrl.crosspol_amp_bias_type_select == $past(word.data[`BIAS_SEL_BIT])
              && ctrl.crosspol_amp_bias_code == $past(word.data[`XBIAS_MSB:`XBIAS_LSB]);
  endproperty
  a_bias_fields: assert property (p_bias_fields)
    else $error("bias fields not taken from written word");

  property p_gain_rx_bias;
    write_hit |=> ctrl.crosspol_amp_gain_code == $past(word.data[`XGAIN_MSB:`XGAIN_LSB])
              && ctrl.receive_gain_stage_bias_code == $past(word.data[`RXBIAS_MSB:`RXBIAS_LSB]);
  endproperty
  a_gain_rx_bias: assert property (p_gain_rx_bias)
    else $error("gain or receive bias code not taken");

  property p_tx_shutdowns;
    write_hit |=> {ctrl.tx_output_stage_shutdown, ctrl.tx_driver_shutdown,
                   ctrl.tx_attenuator_shutdown, ctrl.tx_modulator_shutdown}
                  == $past(word.data[`TX_OUT_BIT:`TX_MOD_BIT]);
  endproperty
  a_tx_shutdowns: assert property (p_tx_shutdowns)
    else $error("transmit shutdown bits wrong");

  property p_rx_shutdowns;
    write_hit |=> {ctrl.rx_baseband_shutdown, ctrl.rx_demodulator_shutdown,
                   ctrl.rx_gain_stage3_shutdown, ctrl.rx_gain_stage2_shutdown,
                   ctrl.rx_gain_stage1_shutdown, ctrl.rx_input_amp_shutdown,
                   ctrl.crosspol_amp_shutdown, ctrl.rx_offset_loop_shutdown,
                   ctrl.temp_sensor_shutdown, ctrl.temp_converter_shutdown}
                  == $past(word.data[`BB_BIT:`TCONV_BIT]);
  endproperty
  a_rx_shutdowns: assert property (p_rx_shutdowns)
    else $error("receive or sensor shutdown bits wrong");

  property p_foreign_ignored;
    word.valid && !addr_match(word.data) && !cal_busy
      |=> $stable(reg_value) && !write_accepted;
  endproperty
  a_foreign_ignored: assert property (p_foreign_ignored)
    else $error("word for another register changed contents");

  property p_reserved_zero;
    write_accepted |-> !reg_value[`RSV_BIT] && addr_match(reg_value);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit or address field wrong");

  // ----------------------------------------------------------------
  // Pulse, contents and sequencer checks
  // ----------------------------------------------------------------
  // A pulse standing two cycles would make the host count one word twice
  property p_accept_pulse;
    write_accepted |=> !write_accepted;
  endproperty
  a_accept_pulse: assert property (p_accept_pulse)
    else $error("write accepted pulse stood too long");

  property p_accept_from_hit;
    write_accepted |-> $past(write_hit);
  endproperty
  a_accept_from_hit: assert property (p_accept_from_hit)
    else $error("write accepted without a matching word");

  property p_addr_kept;
    addr_match(reg_value);
  endproperty
  a_addr_kept: assert property (p_addr_kept)
    else $error("stored address field lost");

  // Only a matching word may move the analog controls
  property p_ctrl_stable;
    !write_hit |=> $stable(ctrl);
  endproperty
  a_ctrl_stable: assert property (p_ctrl_stable)
    else $error("controls changed without a write");

  property p_foreign_busy;
    word.valid && !addr_match(word.data) && cal_busy && !done_rise
      |=> cal_busy && !write_accepted;
  endproperty
  a_foreign_busy: assert property (p_foreign_busy)
    else $error("foreign word disturbed a running calibration");

  // Bit 5 reads back as the running flag, so software can poll it
  property p_busy_bit;
    cal_busy == reg_value[`CAL_BIT];
  endproperty
  a_busy_bit: assert property (p_busy_bit)
    else $error("calibration bit disagrees with busy");

  property p_start_single;
    cal_start |=> !cal_start;
  endproperty
  a_start_single: assert property (p_start_single)
    else $error("calibration start pulse stood too long");

  property p_start_from_write;
    cal_start |-> $past(cal_req);
  endproperty
  a_start_from_write: assert property (p_start_from_write)
    else $error("calibration started without a request");

  property p_start_needs_conv;
    cal_start |-> !ctrl.temp_converter_shutdown;
  endproperty
  a_start_needs_conv: assert property (p_start_needs_conv)
    else $error("calibration started with converter shut down");

  property p_idle_holds;
    !cal_busy && !cal_req |=> !cal_busy;
  endproperty
  a_idle_holds: assert property (p_idle_holds)
    else $error("calibration began on its own");

  property p_busy_holds;
    cal_busy && !done_rise && !conv_off |=> cal_busy;
  endproperty
  a_busy_holds: assert property (p_busy_holds)
    else $error("calibration ended without done or shutdown");

  // A rewrite of bit 5 mid-run must not restart the converter
  property p_restart_ignored;
    cal_busy && cal_req && !done_rise
      |=> cal_busy && !cal_start;
  endproperty
  a_restart_ignored: assert property (p_restart_ignored)
    else $error("running calibration was restarted");

  // Powering the converter down mid-run abandons the calibration
  property p_cal_abort;
    cal_busy && conv_off
      |=> !cal_busy && !reg_value[`CAL_BIT];
  endproperty
  a_cal_abort: assert property (p_cal_abort)
    else $error("calibration not abandoned on converter shutdown");

  property p_refused_clear;
    write_hit && word.data[`CAL_BIT] && word.data[`TCONV_BIT] && !cal_busy
      |=> !cal_busy && !reg_value[`CAL_BIT];
  endproperty
  a_refused_clear: assert property (p_refused_clear)
    else $error("refused calibration left bit 5 set");

  // Scenario coverage; the done window spans one further serial word
  c_cal_cycle:    cover property (cal_start ##[1:1000] (cal_busy && done_rise) ##1 !cal_busy);
  c_cal_abort:    cover property (cal_busy && conv_off ##1 !cal_busy);
  c_write:        cover property (write_hit ##1 write_accepted);
  c_foreign_word: cover property (word.valid && !addr_match(word.data));
  c_cal_refused:  cover property (write_hit && word.data[`CAL_BIT] && word.data[`TCONV_BIT]);

endmodule
`default_nettype wire

// *** host_serial_model.sv ***
// Host controller model: shifts words into the serial programming pins.
// Assumes the caller picks each word; pins change only at falling clk edges.
`timescale 1ns/1ps
`default_nettype none

module host_serial_model (
  input  wire logic clk,        // Bench clock, pins move on its falling edge
  output logic      ser_clk,    // Serial clock, still between frames
  output logic      ser_data,   // Serial data, bit 0 first
  output logic      ser_latch   // Latch enable, rising edge ends a word
);
  initial begin
    ser_clk   = 1'b0;
    ser_data  = 1'b0;
    ser_latch = 1'b0;
  end

  // ----------------------------------------
  // Frame transfer
  // ----------------------------------------
  // Each level is held at least 5 clk, above the 3 clk the sync needs
  task automatic send_frame(input logic [63:0] w, input int n);
    begin
      for (int i = 0; i < n; i++) begin
        @(negedge clk);
        ser_data = w[i];
        repeat (5) @(negedge clk);
        ser_clk = 1'b1;
        repeat (5) @(negedge clk);
        ser_clk = 1'b0;
      end
      repeat (5) @(negedge clk);
      // Data no longer owned, so it shows the inverse of the last bit
      ser_data  = ~ser_data;
      ser_latch = 1'b1;
      repeat (5) @(negedge clk);
      ser_latch = 1'b0;
    end
  endtask
endmodule

`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the power-down and bias control register.
// Assumes host_serial_model drives the pins; expectations come from the field map.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end

module tb;
  import power_bias_pkg::*;

  logic           clk;
  logic           reset_n;
  logic           temp_cal_done;
  wire logic      ser_clk;
  wire logic      ser_data;
  wire logic      ser_latch;
  pwr_bias_ctrl_t ctrl;
  logic [31:0]    reg_value;
  logic           write_accepted;
  logic           cal_start;
  logic           cal_busy;
  int             err_total;
  int             samples_checked;
  int             acc_cnt;
  int             cal_cnt;

  // ----------------------------------------
  // Clock, model and design
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  host_serial_model host (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_latch(ser_latch));

  power_bias_control_register DUT (
    .clk(clk), .reset_n(reset_n), .ser_clk(ser_clk), .ser_data(ser_data),
    .ser_latch(ser_latch), .temp_cal_done(temp_cal_done), .ctrl(ctrl),
    .reg_value(reg_value), .write_accepted(write_accepted),
    .cal_start(cal_start), .cal_busy(cal_busy));

  // Counting every high cycle also catches pulses that stand too long;
  // the falling edge sees each pulse settled, once per cycle it stands
  always @(negedge clk) begin
    if (write_accepted === 1'b1) acc_cnt++;
    if (cal_start === 1'b1) cal_cnt++;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [24:0] ctrl_of(input logic [31:0] w);
    logic [24:0] r;
    r[24]    = w[6];
    r[23:22] = w[8:7];
    r[21:19] = w[11:9];
    r[18:14] = w[16:12];
    for (int i = 0; i < 14; i++) r[13-i] = w[17+i];
    return r;
  endfunction

  task automatic wr(input logic [63:0] w, input int n, input int acc, input int cal,
                    input logic [31:0] er);
    int a0;
    int c0;
    begin
      a0 = acc_cnt;
      c0 = cal_cnt;
      host.send_frame(w, n);
      repeat (10) @(negedge clk);
      `CHK("accept_count", acc, acc_cnt - a0)
      `CHK("cal_start_count", cal, cal_cnt - c0)
      `CHK("reg_value", er, reg_value)
      `CHK("ctrl", ctrl_of(er), ctrl)
    end
  endtask

  task automatic wrap_up;
    begin
      if (err_total == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    // Roughly twice the length of all scenarios together
    #80000;
    err_total++;
    wrap_up();
  end

  initial begin
    err_total = 0;
    samples_checked = 0;
    acc_cnt = 0;
    cal_cnt = 0;
    reset_n = 1'b0;
    temp_cal_done = 1'b0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    `CHK("reset_value", 32'h0060991C, reg_value)
    `CHK("reset_ctrl", ctrl_of(32'h0060991C), ctrl)
    `CHK("reset_busy", 1'b0, cal_busy)
    wr(64'h0060751C, 32, 1, 0, 32'h0060751C);
    wr(64'h0001FFDC, 32, 1, 0, 32'h0001FFDC);
    wr(64'h0000009C, 32, 1, 0, 32'h0000009C);
    for (int i = 17; i <= 30; i++)
      wr(64'h1C | (64'h1 << i), 32, 1, 0, 32'h1C | (32'h1 << i));
    // Wrong register number, wrong chip address, short and long frames
    wr(64'h0000001B, 32, 0, 0, 32'h4000001C);
    wr(64'h0000000C, 32, 0, 0, 32'h4000001C);
    wr(64'h0000001C, 31, 0, 0, 32'h4000001C);
    wr(64'h0000001C, 33, 0, 0, 32'h4000001C);
    wr(64'h0000003C, 32, 1, 1, 32'h0000003C);
    `CHK("busy_running", 1'b1, cal_busy)
    wr(64'h0000003C, 32, 1, 0, 32'h0000003C);
    temp_cal_done = 1'b1;
    repeat (8) @(negedge clk);
    `CHK("busy_done", 1'b0, cal_busy)
    `CHK("cal_bit_done", 32'h0000001C, reg_value)
    temp_cal_done = 1'b0;
    // Converter switched off mid-run abandons the calibration
    wr(64'h0000003C, 32, 1, 1, 32'h0000003C);
    wr(64'h0020003C, 32, 1, 0, 32'h0020001C);
    `CHK("busy_aborted", 1'b0, cal_busy)
    // Converter held off, so the start request must be dropped
    wr(64'h0020003C, 32, 1, 0, 32'h0020001C);
    reset_n = 1'b0;
    @(negedge clk);
    `CHK("rereset_value", 32'h0060991C, reg_value)
    `CHK("rereset_busy", 1'b0, cal_busy)
    reset_n = 1'b1;
    // The first word after a reset taken with calibration idle must land normally
    wr(64'h0060751C, 32, 1, 0, 32'h0060751C);
    repeat (2) @(negedge clk);
    wrap_up();
  end
endmodule

`default_nettype wire
